// >>> src/acs_params.svh
// Constants of the conversion sequencer: offsets, fields, resets, timing
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Clock rate and timing
`define ACS_MCLK_HZ         32'h0098_9680
`define ACS_START_DELAY_US  32'h0000_0032
`define ACS_START_DELAY_CYC (`ACS_START_DELAY_US * (`ACS_MCLK_HZ / 32'h000F_4240))
`define ACS_OVERHEAD_CYC    32'h0000_0040
`define ACS_RESULT_READY_N_LOW_CYC    32'h0000_0004

// Register byte offsets
`define ACS_OFS_MODE        12'h000
`define ACS_OFS_PERIOD      12'h004
`define ACS_OFS_DELAY       12'h008
`define ACS_OFS_STATUS      12'h00C
`define ACS_OFS_MASK        12'h010
`define ACS_OFS_RESULT      12'h014
`define ACS_OFS_STATE       12'h018

// Reset values
`define ACS_MODE_RST        8'h00
`define ACS_MASK_RST        3'h0
`define ACS_PERIOD_RST      24'h07_A120

// Status bit positions
`define ACS_ST_DONE         0
`define ACS_ST_START        1
`define ACS_ST_ABORT        2

// Serial command codes, arbitrary values
`define ACS_CMD_START       8'h5A
`define ACS_CMD_STOP        8'hA5

// Falling clock edges at which a command acts
`define ACS_EDGES_NOCRC     6'h10
`define ACS_EDGES_CRC       6'h20

// Filter code that selects the FIR filter
`define ACS_FILT_FIR        3'h7

`endif

// >>> src/acs_pkg.sv
// Types shared by the conversion sequencer modules
package acs_pkg;

	// Sequencer states
	typedef enum logic [0:0] {
		ACS_IDLE = 1'b0,
		ACS_RUN  = 1'b1
	} acs_state_t;

	// First mode register layout
	typedef struct packed {
		logic       crc_en;             // Bit 7: serial CRC on
		logic       ac_excite;          // Bit 6: AC excitation
		logic       chop;               // Bit 5: global chop
		logic       single_shot_select; // Bit 4: pulse mode
		logic       rsv;                // Bit 3: reserved
		logic [2:0] filter;             // Bits 2:0: filter code, order minus one up to 4, 7 for FIR
	} acs_mode_t;

	// Serial port pins
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} acs_link_t;

endpackage

// >>> src/acs_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module acs_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta; // First stage, read only by q

	// One pair of flops per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					meta[i] <= 1'b0;
					q[i]    <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i]    <= meta[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> src/acs_cmd_rx.sv
// Serial command receiver: decodes start and stop frames
`timescale 1ns/10ps
`default_nettype none
`include "acs_params.svh"
module acs_cmd_rx
	import acs_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst,
	input  wire acs_link_t link,      // Already synchronised pins
	input  wire logic      crc_en,
	output var  logic      cmd_start,
	output var  logic      cmd_stop
);
	logic       sclk_d;   // Previous clock level
	logic [5:0] edges;    // Falling edges seen in frame
	logic [7:0] opcode;   // First byte of frame
	logic       fall;     // Falling clock edge in frame
	logic [5:0] act_edge; // Edge on which the command acts

	assign fall     = sclk_d & ~link.sclk & ~link.cs_n;
	assign act_edge = crc_en ? `ACS_EDGES_CRC : `ACS_EDGES_NOCRC;

	// Clock edge history
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			sclk_d <= 1'b0;
		else
			sclk_d <= link.sclk;
	end

	// Edge count and opcode shift; a frame restarts when select rises
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			edges  <= 6'h00;
			opcode <= 8'h00;
		end else if (link.cs_n) begin
			edges  <= 6'h00;
		end else if (fall) begin
			if (edges != 6'h3F)
				edges <= edges + 6'h01;
			if (edges < 6'h08)
				opcode <= {opcode[6:0], link.mosi};
		end
	end

	// Command acts on the chosen falling edge only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_start <= 1'b0;
			cmd_stop  <= 1'b0;
		end else begin
			cmd_start <= fall && (edges + 6'h01 == act_edge)
				&& (opcode == `ACS_CMD_START);
			cmd_stop  <= fall && (edges + 6'h01 == act_edge)
				&& (opcode == `ACS_CMD_STOP);
		end
	end
endmodule
`default_nettype wire

// >>> src/acs_seq.sv
// Conversion sequencer with APB registers and serial command control
// Overview of operation
// - Start pin or start command starts conversions
// - Commands act on edge 16, or 32 with CRC
// - Mode bit 4 picks continuous or pulse
// - Continuous mode converts until stopped
// - Ready high at start, low at result
// - Continuous stop finishes current conversion
// - Restart event aborts and restarts conversion
// - Pulse mode: one result per start
// - Pulse mode stop never cuts conversion short
// - FIR and sinc1 settle in one period
// - First latency is delay plus processing
// - Later results every data-rate period
// - Chop doubles first latency, slows later ones
// - Programmable start delay, default fifty microseconds
// - Chop alternates polarity, withholds first, halves difference
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "acs_params.svh"
module acs_seq
	import acs_pkg::*;
#(
	parameter logic [23:0] PERIOD_DEFAULT = `ACS_PERIOD_RST
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        start_pin,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	input  wire logic [23:0] raw_sample,
	output var  logic        result_ready_n,
	output var  logic        chop_phase,
	output logic             irq
);
	// Register state
	acs_mode_t   first_mode_register; // Mode and filter select
	logic [23:0] period;              // Cycles per data-rate period
	logic [23:0] delay;               // Start delay in cycles
	logic [2:0]  status;              // Sticky events
	logic [2:0]  mask;                // Interrupt enables
	logic [23:0] result;              // Last output word

	// Sequencer state
	acs_state_t  state;     // Idle or converting
	logic [31:0] cnt;       // Cycles left in conversion
	logic        keep;      // Continuous run requested
	logic        withhold;  // Current result is not output
	logic [31:0] low_cnt;   // Ready-low pulse timer
	logic [23:0] prev;      // Previous chop-phase sample

	// Synchronised pins and edges
	logic        start_s;   // Start pin after two flops
	logic        start_d;   // Previous start pin level
	acs_link_t   link_raw;  // Serial pins from outside
	acs_link_t   link_s;    // Serial pins after two flops
	logic        cmd_start; // Start command pulse
	logic        cmd_stop;  // Stop command pulse

	// Combinational helpers
	logic        start_ev;  // Any start event
	logic        stop_ev;   // Any stop event
	logic        conv_end;  // Counter expires this cycle
	logic        cont_next; // Another conversion follows
	logic        chopping;  // Chop or AC excitation on
	logic [2:0]  order;     // Settling conversions of filter
	logic [31:0] first_lat; // Normal first-conversion latency
	logic [31:0] follow;    // Period of later conversions
	logic [24:0] diff;      // Chop difference
	logic        wr;        // APB write strobe
	logic        mapped;    // Address hits a register
	logic [2:0]  ev;        // Events setting status

	assign link_raw = '{cs_n: spi_cs_n, sclk: spi_sclk, mosi: spi_mosi};

	// Pins cross into mclk through two flops each
	acs_sync #(.W(4)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({start_pin, link_raw}),
		.q    ({start_s, link_s})
	);

	// Serial command decode
	acs_cmd_rx u_cmd (
		.mclk      (mclk),
		.rst       (rst),
		.link      (link_s),
		.crc_en    (first_mode_register.crc_en),
		.cmd_start (cmd_start),
		.cmd_stop  (cmd_stop)
	);

	// Start pin edge history
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			start_d <= 1'b0;
		else
			start_d <= start_s;
	end

	// Pin and command share one sequencer; a low-high toggle restarts
	assign start_ev = (start_s & ~start_d) | cmd_start;
	assign stop_ev  = (~start_s & start_d) | cmd_stop;
	assign chopping = first_mode_register.chop
		| first_mode_register.ac_excite;

	// FIR and sinc1 settle in one period; higher orders need more
	always_comb begin
		if (first_mode_register.filter == `ACS_FILT_FIR)
			order = 3'h1;
		else if (first_mode_register.filter > 3'h4)
			order = 3'h5;
		else
			order = first_mode_register.filter + 3'h1;
	end

	// Load values for the conversion counter
	assign first_lat = {8'h00, delay}
		+ 32'({order} * {period}) + `ACS_OVERHEAD_CYC;
	assign follow = chopping ? first_lat : {8'h00, period};

	assign conv_end  = (state == ACS_RUN) && (cnt == 32'h0000_0000)
		&& !start_ev;
	// Pulse mode ends after one result; stop lets the current one end
	assign cont_next = withhold | (~first_mode_register.single_shot_select
		& keep & ~stop_ev);

	// Conversion state and counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ACS_IDLE;
			cnt   <= 32'h0000_0000;
		end else if (start_ev) begin
			// Abort anything running and begin again
			state <= ACS_RUN;
			cnt   <= first_lat - 32'h0000_0001;
		end else if (state == ACS_RUN) begin
			if (cnt != 32'h0000_0000)
				cnt <= cnt - 32'h0000_0001;
			else if (withhold)
				cnt <= first_lat - 32'h0000_0001;
			else if (cont_next)
				cnt <= follow - 32'h0000_0001;
			else
				state <= ACS_IDLE;
		end
	end

	// Run request, cleared by stop, set by start
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			keep <= 1'b0;
		else if (start_ev)
			keep <= 1'b1;
		else if (stop_ev)
			keep <= 1'b0;
	end

	// First chop conversion is withheld, doubling first latency
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			withhold <= 1'b0;
		else if (start_ev)
			withhold <= chopping;
		else if (conv_end)
			withhold <= 1'b0;
	end

	// Polarity alternates each conversion while chopping
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			chop_phase <= 1'b0;
		else if (start_ev)
			chop_phase <= 1'b0;
		else if (conv_end && chopping)
			chop_phase <= ~chop_phase;
	end

	// Ready: high when a conversion starts, low when data are ready
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			result_ready_n <= 1'b1;
			low_cnt        <= 32'h0000_0000;
		end else if (start_ev) begin
			result_ready_n <= 1'b1;
			low_cnt        <= 32'h0000_0000;
		end else if (conv_end && !withhold) begin
			result_ready_n <= 1'b0;
			low_cnt        <= `ACS_RESULT_READY_N_LOW_CYC;
		end else if (low_cnt != 32'h0000_0000) begin
			low_cnt <= low_cnt - 32'h0000_0001;
			// Back-to-back conversion: ready low only briefly
			if (low_cnt == 32'h0000_0001 && state == ACS_RUN)
				result_ready_n <= 1'b1;
		end
	end

	// Difference of opposite-phase conversions, halved into the result
	assign diff = chop_phase ? ({raw_sample[23], raw_sample}
		- {prev[23], prev}) : ({prev[23], prev}
		- {raw_sample[23], raw_sample});

	// Result word and previous sample
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			result <= 24'h00_0000;
			prev   <= 24'h00_0000;
		end else if (conv_end) begin
			prev <= raw_sample;
			if (!withhold)
				result <= chopping ? diff[24:1] : raw_sample;
		end
	end

	// Events: done, started, aborted
	always_comb begin
		ev                = 3'h0;
		ev[`ACS_ST_DONE]  = conv_end & ~withhold;
		ev[`ACS_ST_START] = start_ev;
		ev[`ACS_ST_ABORT] = start_ev & (state == ACS_RUN);
	end

	// APB decode; zero wait states
	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	always_comb begin
		case (paddr)
			`ACS_OFS_MODE,
			`ACS_OFS_PERIOD,
			`ACS_OFS_DELAY,
			`ACS_OFS_STATUS,
			`ACS_OFS_MASK,
			`ACS_OFS_RESULT,
			`ACS_OFS_STATE: mapped = 1'b1;
			default:        mapped = 1'b0;
		endcase
	end
	// Unmapped access answers with an error
	assign pslverr = psel & penable & ~mapped;

	// Writable configuration registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			first_mode_register <= `ACS_MODE_RST;
			period              <= PERIOD_DEFAULT;
			delay               <= 24'(`ACS_START_DELAY_CYC);
			mask                <= `ACS_MASK_RST;
		end else if (wr) begin
			case (paddr)
				`ACS_OFS_MODE:   first_mode_register <= pwdata[7:0];
				`ACS_OFS_PERIOD: period <= pwdata[23:0];
				`ACS_OFS_DELAY:  delay  <= pwdata[23:0];
				`ACS_OFS_MASK:   mask   <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Sticky status; a new event wins over a write-one clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			status <= 3'h0;
		else if (wr && paddr == `ACS_OFS_STATUS)
			status <= (status & ~pwdata[2:0]) | ev;
		else
			status <= status | ev;
	end

	// Level interrupt while any unmasked event is pending
	assign irq = |(status & mask);

	// Read data registered in the setup phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`ACS_OFS_MODE:   prdata <= {24'h00_0000,
					first_mode_register};
				`ACS_OFS_PERIOD: prdata <= {8'h00, period};
				`ACS_OFS_DELAY:  prdata <= {8'h00, delay};
				`ACS_OFS_STATUS: prdata <= {29'h0000_0000, status};
				`ACS_OFS_MASK:   prdata <= {29'h0000_0000, mask};
				`ACS_OFS_RESULT: prdata <= {8'h00, result};
				`ACS_OFS_STATE:  prdata <= {27'h000_0000,
					withhold, result_ready_n, chop_phase, keep,
					state == ACS_RUN};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> testbench/acs_seq_monitor.sv
// Port checker of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_seq_monitor #(
	parameter logic [23:0] PERIOD_DEFAULT = 24'h07_A120
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        start_pin,
	input wire logic        result_ready_n,
	input wire logic        chop_phase,
	input wire logic        irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic   acc;    // Access phase
	logic [23:0] hi_cnt; // Busy cycles so far
	assign acc = psel && penable;
	// Busy length; a short one means a wrong count load
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			hi_cnt <= 24'h00_0000;
		else if (result_ready_n)
			hi_cnt <= hi_cnt + 24'h00_0001;
		else
			hi_cnt <= 24'h00_0000;
	end
	property p_zero_wait; acc |-> pready; endproperty
	a_zero_wait: assert property (p_zero_wait)
		else $error("pready low in access phase");
	property p_unmapped;
		acc && paddr >= 12'h01C |-> pslverr && (pwrite || prdata == 0);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_mapped; acc && paddr <= 12'h018 |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped access refused");
	property p_err_idle; !acc |-> !pslverr; endproperty
	a_err_idle: assert property (p_err_idle)
		else $error("error outside access phase");
	property p_start_seen; $rose(start_pin) |-> ##[1:8] result_ready_n;
	endproperty
	a_start_seen: assert property (p_start_seen)
		else $error("start did not raise ready line");
	property p_low_hold; $fell(result_ready_n) |-> (!result_ready_n)[*4];
	endproperty
	a_low_hold: assert property (p_low_hold)
		else $error("result flag too short");
	property p_min_conv;
		$fell(result_ready_n) |-> hi_cnt >= PERIOD_DEFAULT - 24'h00_0005;
	endproperty
	a_min_conv: assert property (p_min_conv)
		else $error("conversion shorter than one period");
	property p_reset_out;
		$fell(rst) |-> result_ready_n && !irq && !chop_phase;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs not at reset level");
	c_result: cover property ($fell(result_ready_n));
	c_error: cover property (acc && pslverr);
	c_irq: cover property ($rose(irq));
endmodule
bind acs_seq acs_seq_monitor #(.PERIOD_DEFAULT(PERIOD_DEFAULT)) mon_u (
	.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .start_pin(start_pin),
	.result_ready_n(result_ready_n), .chop_phase(chop_phase),
	.irq(irq)
);
`default_nettype wire

// >>> testbench/acs_host.sv
// Host model: start pin and serial command frames
`timescale 1ns/10ps
`default_nettype none
module acs_host (
	input  wire logic mclk,
	output var  logic start_pin,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic mosi
);
	// Idle link: clock still, frame closed
	initial begin
		start_pin = 1'b0;
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b1;
	end
	// Pin level, called just after a clock edge
	task automatic pin(input logic v);
		start_pin <= v;
	endtask
	// Frame of n falling edges, opcode first; pin left alone
	// Data change on the rising edge so each bit stands at the fall
	task automatic send(input logic [7:0] op, input int n);
		@(posedge mclk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge mclk);
			sclk <= 1'b1;
			mosi <= (i < 8) ? op[7 - i] : 1'b0;
			repeat (4) @(posedge mclk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		mosi <= ~mosi; // Released: no stale bit
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int PER = 20;                // Short data-rate period
	localparam int DLY = 5;                 // Short start delay
	localparam int L1 = DLY + PER + 64;     // Sinc1 or FIR latency
	localparam int L3 = DLY + 3 * PER + 64; // Sinc3 latency
	localparam logic [23:0] SA = 24'h00_0100; // Sample up to first result
	localparam logic [23:0] SB = 24'h00_0040; // Sample after it
	// One conversion case
	typedef struct packed {
		logic [7:0]  mode;  // Mode byte
		logic        spi;   // Started by command
		int          first; // Cycles to first result
		int          next;  // Spacing, 0 in pulse mode
		logic [23:0] res;   // Result word at the end
	} acs_row_t;
	// Chop halves the opposite-phase difference: (SA - SB) / 2
	acs_row_t rows [8] = '{
		'{8'h00, 1'b0, L1, PER, SB},
		'{8'h02, 1'b0, L3, PER, SB},
		'{8'h20, 1'b0, 2 * L1, L1, 24'h00_0060},
		'{8'h40, 1'b0, 2 * L1, L1, 24'h00_0060},
		'{8'h10, 1'b0, L1, 0, SA},
		'{8'h17, 1'b1, L1, 0, SA},
		'{8'h00, 1'b1, L1, PER, SB},
		'{8'h90, 1'b1, L1, 0, SA}
	};
	logic [23:0] sample = 24'h00_0000; // Filter output fed to the block
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] q;       // Last read data
	logic        e;       // Last slave error
	logic        pready;
	logic        pslverr;
	logic        start_pin;
	logic        cs_n;
	logic        sclk;
	logic        mosi;
	logic        result_ready_n;
	logic        chop;
	logic        irq;
	int          num_errors = 0;
	int          tests_run = 0;
	int          n;
	int          m;
	acs_seq #(.PERIOD_DEFAULT(24'(PER))) dut_u (
		.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.start_pin(start_pin), .spi_cs_n(cs_n), .spi_sclk(sclk),
		.spi_mosi(mosi), .raw_sample(sample),
		.result_ready_n(result_ready_n), .chop_phase(chop), .irq(irq)
	);
	acs_host host_u (.mclk(mclk), .start_pin(start_pin), .cs_n(cs_n),
		.sclk(sclk), .mosi(mosi));
	initial begin
		forever #50 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One comparison
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge mclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		if (k == 16) begin
			chk("bus wait", 32'h0000_0000, 32'h0000_0001);
			end_of_test();
		end
	endtask
	task automatic apb_rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		apb(a, 1'b0, 32'h0000_0000);
		chk("read data", x, q);
		chk("slave error", {31'h0, xe}, {31'h0, e});
	endtask
	// Edges until the ready line reads v, bounded
	task automatic wait_rdy(input logic v, output int c);
		for (c = 1; c <= 2000; c++) begin
			@(posedge mclk);
			#1;
			if (result_ready_n === v)
				return;
		end
		chk("ready wait", 32'h0000_0000, 32'h0000_0001);
		end_of_test();
	endtask
	// Ready must settle low and stay low: nothing restarts
	task automatic quiet();
		logic bad;
		bad = 1'b0;
		repeat (250) @(posedge mclk);
		repeat (300) begin
			@(posedge mclk);
			#1;
			if (result_ready_n !== 1'b0)
				bad = 1'b1;
		end
		chk("idle ready", 32'h0000_0000, {31'h0, bad});
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		apb(12'h008, 1'b1, 32'(DLY));
		apb(12'h000, 1'b1, 32'h0000_0010);
		host_u.pin(1'b1);
		wait_rdy(1'b0, n);
		host_u.pin(1'b0);
		quiet();
		for (int r = 0; r < 8; r++) begin
			apb(12'h000, 1'b1, {24'h00_0000, rows[r].mode});
			sample <= SA;
			if (rows[r].spi)
				fork
					host_u.send(8'h5A, rows[r].mode[7] ? 32 : 16);
				join_none
			else
				host_u.pin(1'b1);
			wait_rdy(1'b1, n);
			if (rows[r].next == 0)
				host_u.pin(1'b0);
			wait_rdy(1'b0, n);
			chk("first result", 32'(rows[r].first), 32'(n));
			sample <= SB;
			if (rows[r].next != 0) begin
				wait_rdy(1'b1, n);
				wait_rdy(1'b0, m);
				chk("spacing", 32'(rows[r].next), 32'(n + m));
				// Third conversion ends in the reversed phase
				chk("chop phase", {31'h0, |rows[r].mode[6:5]},
					{31'h0, chop});
				if (rows[r].spi)
					fork
						host_u.send(8'hA5, 16);
					join_none
				host_u.pin(1'b0);
			end
			apb_rd(12'h014, {8'h00, rows[r].res}, 1'b0);
			quiet();
		end
		// Sixteen edges are too few once CRC is on
		apb(12'h000, 1'b1, 32'h0000_0090);
		host_u.send(8'h5A, 16);
		quiet();
		// Restart mid-conversion, then the interrupt path
		apb(12'h000, 1'b1, 32'h0000_0010);
		apb(12'h00C, 1'b1, 32'h0000_0007);
		host_u.pin(1'b1);
		wait_rdy(1'b1, n);
		repeat (30) @(posedge mclk);
		host_u.pin(1'b0);
		repeat (5) @(posedge mclk);
		host_u.pin(1'b1);
		wait_rdy(1'b0, n);
		chk("restart", 32'h1, 32'(n >= L1 && n <= L1 + 8));
		apb_rd(12'h00C, 32'h0000_0007, 1'b0);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(12'h010, 1'b1, 32'h0000_0007);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(12'h00C, 1'b1, 32'h0000_0007);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb_rd(12'h00C, 32'h0000_0000, 1'b0);
		host_u.pin(1'b0);
		// Second reset: registers back to reset values
		apb(12'h004, 1'b1, 32'h0000_0030);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk("ready at reset", 32'h1, {31'h0, result_ready_n});
		apb_rd(12'h000, 32'h0000_0000, 1'b0);
		apb_rd(12'h004, 32'(PER), 1'b0);
		apb_rd(12'h008, 32'h0000_01F4, 1'b0);
		apb_rd(12'h010, 32'h0000_0000, 1'b0);
		apb_rd(12'h01C, 32'h0000_0000, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
